// ==== phase_stage.sv ====
// phase enable staging: drops phases at once, adds one per pwm cycle
// assumes tick is a one-cycle pulse per switching cycle on the same clock
`timescale 1ns/10ps
`default_nettype none
module phase_stage #(parameter int N = 6) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic [N-1:0] want,
   output logic [N-1:0] live
);
   logic [N-1:0] add;
   logic [N-1:0] miss;
   assign miss = want & ~live;
   // lowest missing phase first, so phases wake in ascending order
   assign add = miss & ~(miss - N'(1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         live <= '0;
      end else if (tick) begin
         live <= (live & want) | add;
      end else begin
         live <= live & want;
      end
   end
endmodule : phase_stage
`default_nettype wire

// ==== pin_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
// assumes nothing of the inputs beyond being levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(parameter int W = 1) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ==== regulator_sequencer.sv ====
// state sequencer of a multi-phase regulator controller
// assumes a classic wishbone master, an nvm port and a pwm modulator on sys_clk
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module regulator_sequencer
   import seq_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYC,
   parameter int HICCUP_CYCLES = HICCUP_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic en_pin,
   input wire logic vin_ok_pin,
   input wire logic overtemp_pin,
   input wire logic abs_ov_pin,
   input wire logic ov_pin,
   input wire logic uv_pin,
   input wire logic oc_pin,
   input wire logic [7:0] vout_sense,
   input wire logic [5:0] pwm_mod,
   input wire logic pwm_tick,
   output logic nvm_load_req,
   input wire logic nvm_load_done,
   input wire logic nvm_load_ok,
   input wire logic [31:0] nvm_load_data,
   output logic nvm_store_req,
   output logic [31:0] nvm_store_data,
   input wire logic nvm_store_done,
   output logic [5:0] pwm_o,
   output logic [5:0] pwm_oe,
   output logic forced_continuous_output,
   output logic alert_n_o,
   output logic alert_oe,
   output logic regulator_ready_out
);
   // ************************************
   // functions
   // ************************************
   // 3'b100 prints twice in the phase table; the four-phase reading is used
   function automatic logic [5:0] phase_mask(input logic [2:0] code);
      case (code)
         3'b011: phase_mask = 6'h07;
         3'b100: phase_mask = 6'h0f;
         3'b101: phase_mask = 6'h1f;
         default: phase_mask = 6'h3f;
      endcase
   endfunction : phase_mask

   function automatic logic [31:0] byte_merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      byte_merge = r;
   endfunction : byte_merge

   // ************************************
   // pins and bus decode
   // ************************************
   logic en_s, vin_ok_s, ot_s, abs_ov_s, ov_s, uv_s, oc_s;
   pin_sync #(.W(7)) u_sync (
      .clk(sys_clk),
      .rst(rst),
      .d({en_pin, vin_ok_pin, overtemp_pin, abs_ov_pin, ov_pin, uv_pin, oc_pin}),
      .q({en_s, vin_ok_s, ot_s, abs_ov_s, ov_s, uv_s, oc_s})
   );

   state_t state;
   logic [31:0] cfg;
   logic [7:0] vref;
   logic [7:0] vtgt;
   logic [1:0] ps;
   logic alert, reject, fast_rate, vset_busy, ov_latch, prebias, pb_q, ph1_hold;
   logic ld_busy, ld_sent, st_busy;
   logic [31:0] init_cnt;
   logic [31:0] hic_cnt;
   logic [7:0] div_cnt;
   logic [7:0] min_cnt;
   logic [5:0] want;
   logic [5:0] live;

   logic acc, wr, rd, ctrl_wr, vset_wr, pset_wr, cfg_wr, stat_rd;
   logic fclr, reload, store, prst, softoff, immoff, opon;
   logic hard_fault, ov_fault, prot_cond, running, ramping, step, ld_ok, ld_bad;
   logic [7:0] boot, imax;
   logic [5:0] cnt_mask;

   // accesses take effect at the edge where the master sees ack high
   assign acc = wb_cyc_i & wb_stb_i & wb_ack_o;
   assign wr = acc & wb_we_i;
   assign rd = acc & ~wb_we_i;
   assign ctrl_wr = wr & (wb_adr_i == A_CTRL) & wb_sel_i[0];
   assign cfg_wr = wr & (wb_adr_i == A_CONFIG);
   assign vset_wr = wr & (wb_adr_i == A_VSET) & wb_sel_i[0];
   assign pset_wr = wr & (wb_adr_i == A_PSET) & wb_sel_i[0];
   assign stat_rd = rd & (wb_adr_i == A_STATUS);
   assign fclr = ctrl_wr & wb_dat_i[C_FCLR];
   assign reload = ctrl_wr & wb_dat_i[C_RELOAD];
   assign store = ctrl_wr & wb_dat_i[C_STORE];
   assign prst = ctrl_wr & wb_dat_i[C_PRST];
   assign softoff = ctrl_wr & wb_dat_i[C_SOFTOFF];
   assign immoff = ctrl_wr & wb_dat_i[C_IMMOFF];
   assign opon = ctrl_wr & wb_dat_i[C_OPON];

   assign boot = cfg[BOOT_LSB +: 8];
   assign imax = cfg[IMAX_LSB +: 8];
   assign cnt_mask = phase_mask(cfg[PH_LSB +: 3]);
   assign hard_fault = uv_s | oc_s | ot_s | ~vin_ok_s;
   assign ov_fault = ov_s | abs_ov_s;
   assign prot_cond = ~vin_ok_s | ot_s | abs_ov_s;
   assign running = (state == ST_SS) | (state == ST_ACTIVE) | (state == ST_SOFTOFF);
   assign ramping = vref != vtgt;
   assign ld_ok = nvm_load_done & nvm_load_ok;
   assign ld_bad = nvm_load_done & ~nvm_load_ok;

   // ************************************
   // wishbone slave
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         case (wb_adr_i)
            A_CONFIG: wb_dat_o <= cfg;
            A_VSET: wb_dat_o <= {23'h000000, fast_rate, vtgt};
            A_PSET: wb_dat_o <= {30'h00000000, ps};
            A_STATUS: wb_dat_o <= {8'h00, vref, 4'h0, vset_busy, ov_latch,
               (state == ST_NVM_FAULT), reject, alert, regulator_ready_out, ps, state};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************
   // main state machine
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_LOAD;
      end else if (ov_fault && running) begin
         state <= ST_PROT_WAIT;
      end else if (hard_fault && running) begin
         state <= ST_PROT_WAIT;
      end else if (!en_s && state != ST_EN_WAIT && state != ST_NVM_FAULT
            && state != ST_STORE) begin
         state <= ST_EN_WAIT;
      end else begin
         case (state)
            ST_LOAD: begin
               if (ld_bad || init_cnt >= 32'(INIT_CYCLES)) begin
                  state <= ST_NVM_FAULT;
               end else if (ld_ok) begin
                  state <= prot_cond ? ST_PROT_WAIT : ST_SS;
               end
            end
            ST_NVM_FAULT: begin
               if (store) begin
                  state <= ST_STORE;
               end else if (fclr || vset_wr) begin
                  state <= ST_SS;
               end
            end
            ST_STORE: begin
               if (nvm_store_done) begin
                  state <= ST_LOAD;
               end
            end
            ST_SS: begin
               if (vtgt == 8'h00 || imax == 8'h00) begin
                  state <= ST_ZERO_WAIT;
               end else if (!ramping && step) begin
                  state <= ST_ACTIVE;
               end
            end
            ST_ZERO_WAIT: begin
               if (vset_wr && wb_dat_i[7:0] != 8'h00 && imax != 8'h00) begin
                  state <= ST_SS;
               end
            end
            ST_ACTIVE: begin
               if (immoff) begin
                  state <= ST_OFF;
               end else if (softoff) begin
                  state <= ST_SOFTOFF;
               end
            end
            ST_SOFTOFF: begin
               if (immoff || vref == 8'h00) begin
                  state <= ST_OFF;
               end
            end
            ST_OFF: begin
               if (opon) begin
                  state <= ST_SS;
               end
            end
            ST_EN_WAIT: begin
               if (en_s) begin
                  state <= ST_LOAD;
               end
            end
            ST_PROT_WAIT: begin
               if (prst && !prot_cond && !hard_fault && !ov_fault) begin
                  state <= ST_HICCUP;
               end
            end
            ST_HICCUP: begin
               if (hic_cnt >= 32'(HICCUP_CYCLES)) begin
                  state <= ST_SS;
               end
            end
            default: state <= ST_LOAD;
         endcase
      end
   end

   // ************************************
   // timers
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         init_cnt <= 32'h0000_0000;
         hic_cnt <= 32'h0000_0000;
      end else begin
         init_cnt <= (state == ST_LOAD) ? init_cnt + 32'h1 : 32'h0000_0000;
         hic_cnt <= (state == ST_HICCUP) ? hic_cnt + 32'h1 : 32'h0000_0000;
      end
   end

   // ************************************
   // nvm load and store
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         nvm_load_req <= 1'b0;
         ld_busy <= 1'b0;
         ld_sent <= 1'b0;
      end else begin
         nvm_load_req <= 1'b0;
         if (nvm_load_done) begin
            ld_busy <= 1'b0;
         end
         if (state != ST_LOAD) begin
            ld_sent <= 1'b0;
         end
         if (!ld_busy && ((state == ST_LOAD && !ld_sent) || reload)) begin
            nvm_load_req <= 1'b1;
            ld_busy <= 1'b1;
            ld_sent <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         nvm_store_req <= 1'b0;
         nvm_store_data <= 32'h0000_0000;
         st_busy <= 1'b0;
      end else begin
         nvm_store_req <= 1'b0;
         if (nvm_store_done) begin
            st_busy <= 1'b0;
         end
         if (store && !st_busy) begin
            nvm_store_req <= 1'b1;
            nvm_store_data <= cfg;
            st_busy <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg <= CONFIG_RST;
      end else if (state == ST_NVM_FAULT && (fclr || vset_wr)) begin
         cfg <= CONFIG_RST;
      end else if (ld_ok && state != ST_NVM_FAULT) begin
         cfg <= nvm_load_data;
      end else if (cfg_wr) begin
         cfg <= byte_merge(cfg, wb_dat_i, wb_sel_i);
      end
   end

   // ************************************
   // reference ramp
   // ************************************
   // one divider serves both slew rates; a rate change takes effect at the next reload of the count
   assign step = div_cnt == 8'h00;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 8'h00;
      end else if (step) begin
         div_cnt <= fast_rate ? 8'(FAST_STEP_CYC - 1) : 8'(SLOW_STEP_CYC - 1);
      end else begin
         div_cnt <= div_cnt - 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vref <= 8'h00;
         vtgt <= 8'h00;
         fast_rate <= 1'b0;
      end else begin
         if (vset_wr && (running || state == ST_ZERO_WAIT || state == ST_NVM_FAULT)) begin
            vtgt <= wb_dat_i[7:0];
            fast_rate <= wb_dat_i[VSET_FAST];
         end else if (state == ST_SOFTOFF) begin
            vtgt <= 8'h00;
            fast_rate <= 1'b0;
         end else if (!running && state != ST_ZERO_WAIT) begin
            // take the boot value that config is about to hold, not the one it leaves
            vtgt <= (state == ST_LOAD && ld_ok) ? nvm_load_data[BOOT_LSB +: 8]
               : (state == ST_NVM_FAULT) ? CONFIG_RST[BOOT_LSB +: 8] : boot;
            fast_rate <= 1'b0;
         end
         if (!running) begin
            vref <= 8'h00;
         end else if (step && vref < vtgt) begin
            vref <= vref + 8'h01;
         end else if (step && vref > vtgt) begin
            vref <= vref - 8'h01;
         end
      end
   end

   // ************************************
   // power state, alert, reject
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ps <= PS_FULL;
      end else if (vset_wr || !running) begin
         ps <= PS_FULL;
      end else if (pset_wr && !ramping) begin
         ps <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reject <= 1'b0;
      end else if (pset_wr && ramping) begin
         reject <= 1'b1;
      end else if (stat_rd) begin
         reject <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vset_busy <= 1'b0;
      end else if (vset_wr) begin
         vset_busy <= 1'b1;
      end else if (state == ST_ACTIVE && !ramping) begin
         vset_busy <= 1'b0;
      end
   end

   // set wins over the status read in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert <= 1'b0;
      end else if ((state == ST_SS && !ramping && step && vtgt != 8'h00 && imax != 8'h00)
            || (state == ST_ACTIVE && vset_busy && !ramping)) begin
         alert <= 1'b1;
      end else if (stat_rd) begin
         alert <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert_n_o <= 1'b0;
         alert_oe <= 1'b0;
         regulator_ready_out <= 1'b0;
      end else begin
         alert_oe <= alert;
         regulator_ready_out <= state == ST_ACTIVE;
      end
   end

   // ************************************
   // phase drive
   // ************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ov_latch <= 1'b0;
      end else if (ov_fault && running) begin
         ov_latch <= 1'b1;
      end else if (state != ST_PROT_WAIT) begin
         ov_latch <= 1'b0;
      end
   end

   assign prebias = (state == ST_SS) && (vref <= vout_sense);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pb_q <= 1'b0;
         min_cnt <= 8'h00;
         ph1_hold <= 1'b0;
      end else begin
         pb_q <= prebias;
         // phase one stays driven from its first pulse until the stager takes it over
         if (live[0] || !running || prebias) begin
            ph1_hold <= 1'b0;
         end
         if (pb_q && !prebias && state == ST_SS) begin
            min_cnt <= 8'(MIN_ON_CYC);
            ph1_hold <= 1'b1;
         end else if (min_cnt != 8'h00) begin
            min_cnt <= min_cnt - 8'h01;
         end
      end
   end

   always_comb begin
      want = 6'h00;
      case (state)
         ST_SS: want = prebias ? 6'h00 : cnt_mask;
         ST_ACTIVE: want = (ps == PS_FULL) ? cnt_mask : 6'h01;
         ST_SOFTOFF: want = cnt_mask;
         default: want = 6'h00;
      endcase
   end

   phase_stage #(.N(6)) u_stage (
      .clk(sys_clk),
      .rst(rst),
      .tick(pwm_tick),
      .want(want),
      .live(live)
   );

   // unused or shed phases keep enable low except in overvoltage discharge, so their pins float
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwm_o <= 6'h00;
         pwm_oe <= 6'h00;
         forced_continuous_output <= 1'b0;
      end else begin
         if (ov_latch || (ov_fault && running)) begin
            pwm_o <= 6'h00;
            pwm_oe <= 6'h3f;
         end else if (hard_fault || !en_s || immoff) begin
            pwm_o <= 6'h00;
            pwm_oe <= 6'h00;
         end else begin
            pwm_o <= (pwm_mod & live & want) | {5'h00, min_cnt != 8'h00};
            pwm_oe <= (live & want) | {5'h00, min_cnt != 8'h00 || ph1_hold};
         end
         forced_continuous_output <= running && !prebias && ps < PS_SECOND;
      end
   end
endmodule : regulator_sequencer
`default_nettype wire

// ==== seq_chk.sv ====
// checker for the regulator sequencer
// assumes pins settle through the two-flop synchronisers
`timescale 1ns/10ps
`default_nettype none
module seq_chk
   import seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_ack_o,
   input wire logic vin_ok_pin,
   input wire logic overtemp_pin,
   input wire logic abs_ov_pin,
   input wire logic ov_pin,
   input wire logic uv_pin,
   input wire logic oc_pin,
   input wire logic [5:0] pwm_o,
   input wire logic [5:0] pwm_oe,
   input wire logic forced_continuous_output,
   input wire logic alert_oe,
   input wire logic regulator_ready_out
);
   logic hard;
   logic st_rd;
   assign hard = (uv_pin | oc_pin | overtemp_pin | ~vin_ok_pin) & ~ov_pin & ~abs_ov_pin;
   assign st_rd = wb_ack_o & ~wb_we_i & (wb_adr_i == A_STATUS);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ****
   // assertions
   // ****
   AST_TRISTATE: assert property (hard [*5] |-> pwm_oe == 6'h00)
      else $error("phases driven in fault");
   AST_NO_READY: assert property (hard [*5] |-> !regulator_ready_out)
      else $error("ready in fault");
   AST_DISCHARGE: assert property (ov_pin [*5] |-> pwm_o == 6'h00 && pwm_oe == 6'h3f)
      else $error("overvoltage not discharging");
   AST_ONE_UP: assert property ((pwm_oe & ~$past(pwm_oe)) != 6'h00 && !$past(ov_pin, 3)
      && !$past(ov_pin, 4) |-> $onehot(pwm_oe & ~$past(pwm_oe)))
      else $error("phases added together");
   AST_PH1_PULSE: assert property ($rose(pwm_oe[0]) && !ov_pin |-> ##[0:1] pwm_o[0] [*3])
      else $error("no minimum pulse");
   AST_SHED: assert property ((regulator_ready_out && !forced_continuous_output) [*2]
      |-> pwm_oe[5:1] == 5'h00)
      else $error("phases on in light state");
   AST_ALERT_HOLD: assert property (alert_oe && !$past(st_rd) |=> alert_oe)
      else $error("alert dropped early");
   AST_READY_ALERT: assert property ($rose(regulator_ready_out) |-> ##[0:2] alert_oe)
      else $error("no alert at boot");
   cover property ($rose(regulator_ready_out));
   cover property ($fell(alert_oe));
   cover property (ov_pin [*5]);
endmodule : seq_chk
bind regulator_sequencer seq_chk seq_chk_inst (.sys_clk, .rst, .wb_we_i, .wb_adr_i,
   .wb_ack_o, .vin_ok_pin, .overtemp_pin, .abs_ov_pin, .ov_pin, .uv_pin, .oc_pin, .pwm_o,
   .pwm_oe, .forced_continuous_output, .alert_oe, .regulator_ready_out);
`default_nettype wire

// ==== seq_nvm_model.sv ====
// nvm partner model: answers load and store pulses
// assumes request pulses on the sequencer clock
`timescale 1ns/10ps
`default_nettype none
module seq_nvm_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic load_req,
   input wire logic store_req,
   input wire logic good,
   input wire logic [31:0] image,
   output logic load_done,
   output logic load_ok,
   output logic [31:0] load_data,
   output logic store_done
);
   logic [3:0] wait_cnt;
   // ****
   // slow reads, quick writes
   // ****
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_cnt <= 4'h0;
         load_done <= 1'b0;
         store_done <= 1'b0;
      end else begin
         store_done <= store_req;
         load_done <= (wait_cnt == 4'h1);
         if (load_req) begin
            wait_cnt <= 4'h9;
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
   // data is junk outside done so a stale copy is never trusted
   assign load_ok = load_done & good;
   assign load_data = load_done ? image : ~image ^ {8{wait_cnt}};
endmodule : seq_nvm_model
`default_nettype wire

// ==== seq_pkg.sv ====
// constants, field layout and state codes for the regulator sequencer
// assumes a 40 MHz system clock and 32-bit classic wishbone registers
package seq_pkg;
   // ************************************
   // timing
   // ************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int INIT_US = 700;
   localparam int INIT_CYC = INIT_US * CLK_PER_US;
   localparam int HICCUP_US = 12_500;
   localparam int HICCUP_CYC = HICCUP_US * CLK_PER_US;
   localparam int VID_LSB_UV = 5_000;
   localparam int SLOW_UV_PER_US = 5_000;
   localparam int FAST_UV_PER_US = 20_000;
   localparam int SLOW_STEP_CYC = VID_LSB_UV * CLK_PER_US / SLOW_UV_PER_US;
   localparam int FAST_STEP_CYC = VID_LSB_UV * CLK_PER_US / FAST_UV_PER_US;
   localparam int MIN_ON_NS = 100;
   localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_PER_US + 999) / 1000;
   // ************************************
   // register map and fields
   // ************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CONFIG = 8'h04;
   localparam logic [7:0] A_VSET = 8'h08;
   localparam logic [7:0] A_PSET = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam int C_FCLR = 0;
   localparam int C_RELOAD = 1;
   localparam int C_STORE = 2;
   localparam int C_PRST = 3;
   localparam int C_SOFTOFF = 4;
   localparam int C_IMMOFF = 5;
   localparam int C_OPON = 6;
   localparam int BOOT_LSB = 0;
   localparam int PH_LSB = 12;
   localparam int IMAX_LSB = 16;
   localparam int VSET_FAST = 8;
   localparam logic [31:0] CONFIG_RST = 32'h0040_6064;
   // ************************************
   // states and power states
   // ************************************
   typedef enum logic [3:0] {
      ST_LOAD = 4'h0, ST_SS = 4'h1, ST_ACTIVE = 4'h3, ST_SOFTOFF = 4'h2,
      ST_OFF = 4'h6, ST_EN_WAIT = 4'h7, ST_PROT_WAIT = 4'h5, ST_HICCUP = 4'h4,
      ST_NVM_FAULT = 4'hc, ST_STORE = 4'hd, ST_ZERO_WAIT = 4'hf
   } state_t;
   localparam logic [1:0] PS_FULL = 2'h0;
   localparam logic [1:0] PS_SECOND = 2'h2;
endpackage : seq_pkg

// ==== testbench.sv ====
// self-checking bench for the regulator sequencer
// assumes the nvm model and short init and hiccup counts
`timescale 1ns/10ps
`default_nettype none
module testbench
   import seq_pkg::*;
;
   localparam logic [31:0] img = 32'h0040_3020;
   logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, vout_sense = 8'h08, rnd = 8'h43;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, nvm_load_data, nvm_store_data, q;
   logic [3:0] wb_sel_i = 4'hf;
   logic en_pin = 1'b1, vin_ok_pin = 1'b1, overtemp_pin = 1'b0, abs_ov_pin = 1'b0;
   logic ov_pin = 1'b0, uv_pin = 1'b0, oc_pin = 1'b0, pwm_tick = 1'b0, good = 1'b1;
   logic [5:0] pwm_mod = 6'h00, pwm_o, pwm_oe;
   logic [2:0] tcnt = 3'h0, c;
   logic wb_ack_o, nvm_load_req, nvm_load_done, nvm_load_ok, nvm_store_req, nvm_store_done;
   logic forced_continuous_output, alert_n_o, alert_oe, regulator_ready_out;
   int fail_count = 0, checks_done = 0;
   regulator_sequencer #(.INIT_CYCLES(200), .HICCUP_CYCLES(100)) regulator_sequencer_inst (
      .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o, .en_pin, .vin_ok_pin, .overtemp_pin, .abs_ov_pin, .ov_pin,
      .uv_pin, .oc_pin, .vout_sense, .pwm_mod, .pwm_tick, .nvm_load_req, .nvm_load_done,
      .nvm_load_ok, .nvm_load_data, .nvm_store_req, .nvm_store_data, .nvm_store_done,
      .pwm_o, .pwm_oe, .forced_continuous_output, .alert_n_o, .alert_oe, .regulator_ready_out);
   seq_nvm_model seq_nvm_model_inst (.clk(sys_clk), .rst, .load_req(nvm_load_req),
      .store_req(nvm_store_req), .good, .image(img), .load_done(nvm_load_done),
      .load_ok(nvm_load_ok), .load_data(nvm_load_data), .store_done(nvm_store_done));
   always #12.5 sys_clk = ~sys_clk;
   // ****
   // helpers
   // ****
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [5:0] ph_mask(input logic [2:0] k);
      case (k)
         3'h3: return 6'h07;
         3'h4: return 6'h0f;
         3'h5: return 6'h1f;
         default: return 6'h3f;
      endcase
   endfunction : ph_mask
   always @(posedge sys_clk) begin
      rnd <= lfsr(rnd);
      pwm_mod <= rnd[5:0];
      tcnt <= tcnt + 3'h1;
      pwm_tick <= (tcnt == 3'h7);
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   // polling gives up after a bound, so a missing state counts as a mismatch
   task automatic poll(input logic [3:0] s);
      int n;
      n = 0;
      do begin
         wb(1'b0, A_STATUS, 32'h0);
         n++;
      end while (q[3:0] !== s && n < 3000);
      cmp(32'(q[3:0]), 32'(s));
   endtask : poll
   task automatic conclude();
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   // ****
   // scenarios
   // ****
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // a poll could clear the alert unseen, so wait out the slow ramp to boot
      repeat (1600) @(posedge sys_clk);
      wb(1'b0, A_STATUS, 32'h0);
      cmp(32'(q[7:0]), 32'hc3);
      wb(1'b0, A_STATUS, 32'h0);
      cmp(32'(q[7:6]), 32'h1);
      wb(1'b0, A_CONFIG, 32'h0);
      cmp(q, img);
      wb(1'b0, 8'h40, 32'h0);
      cmp(q, 32'h0);
      for (int i = 0; i < 5; i++) begin
         c = (i == 0) ? rnd[2:0] : 3'(i + 2);
         wb(1'b1, A_CONFIG, {img[31:15], c, img[11:0]});
         repeat (80) @(posedge sys_clk);
         cmp(32'(pwm_oe), 32'(ph_mask(c)));
      end
      wb(1'b1, A_PSET, 32'h2);
      repeat (4) @(posedge sys_clk);
      cmp(32'({forced_continuous_output, pwm_oe}), 32'h01);
      wb(1'b1, A_VSET, 32'h22);
      repeat (160) @(posedge sys_clk);
      cmp(32'({forced_continuous_output, pwm_oe}), 32'h7f);
      wb(1'b0, A_STATUS, 32'h0);
      cmp(32'(q[5:4]), 32'h0);
      uv_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cmp(32'({alert_n_o, pwm_oe}), 32'h0);
      poll(4'h5);
      uv_pin <= 1'b0;
      en_pin <= 1'b0;
      poll(4'h7);
      en_pin <= 1'b1;
      poll(4'h3);
      ov_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cmp(32'({pwm_o, pwm_oe}), 32'h03f);
      poll(4'h5);
      ov_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      wb(1'b1, A_CTRL, 32'h8);
      poll(4'h4);
      poll(4'h3);
      wb(1'b1, A_CTRL, 32'h10);
      poll(4'h6);
      wb(1'b1, A_CTRL, 32'h40);
      poll(4'h3);
      wb(1'b1, A_CTRL, 32'h20);
      repeat (3) @(posedge sys_clk);
      cmp(32'(pwm_oe), 32'h0);
      good <= 1'b0;
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      poll(4'hc);
      good <= 1'b1;
      wb(1'b1, A_CONFIG, img);
      wb(1'b1, A_CTRL, 32'h1);
      wb(1'b0, A_CONFIG, 32'h0);
      cmp(q, CONFIG_RST);
      poll(4'h3);
      wb(1'b1, A_VSET, 32'h150);
      repeat (300) @(posedge sys_clk);
      wb(1'b0, A_STATUS, 32'h0);
      cmp(32'(q[23:16]), 32'h50);
      wb(1'b1, A_CTRL, 32'h2);
      repeat (20) @(posedge sys_clk);
      wb(1'b0, A_CONFIG, 32'h0);
      cmp(q, img);
      wb(1'b1, A_CTRL, 32'h4);
      cmp(nvm_store_data, img);
      wb(1'b1, A_CONFIG, {img[31:8], 8'h00});
      wb(1'b1, A_CTRL, 32'h20);
      wb(1'b1, A_CTRL, 32'h40);
      poll(4'hf);
      cmp(32'(pwm_oe), 32'h0);
      wb(1'b1, A_VSET, 32'h20);
      poll(4'h3);
      conclude();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      fail_count++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
